// [verilog/input_capture_filter_regs.sv]
// The plain strobed port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
// What this block does
// - Rise parameter is acceptance time, immediate mode
// - Rise parameter is deglitch time, deglitch mode
// - Fall parameter is acceptance time, immediate mode
// - Fall parameter is deglitch time, deglitch mode
// - Parameter top byte reads zero
// - Capture A from extension plus select
// - Capture B from extension plus select
// - Bit compression: B gets filter output only
// - Capture B writable only in gated sampling
// - Edge tally counts both edges, top byte
// - Tally LSB mirrors filtered level
// - Enable clears tally, LSB takes level
// - Capture A read-only to software
// - No legacy timeout duration register
// - Rise mode bit: 0 immediate, 1 deglitch
// - Fall mode bit: 0 immediate, 1 deglitch
// - Enable resets tally, counter, captures
// - Two-bit select picks prescaled clock tick
module input_capture_filter_regs (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic reset_i,
    // Register port
    input wire capture_filter_pkg::reg_req_t reg_req_i,
    output logic [capture_filter_pkg::DATA_W-1:0] reg_rdata_o,
    // Channel signals
    input wire logic filter_in_i,
    input wire logic [3:0] prescaled_clock_i,
    input wire logic capture_strobe_i,
    input wire capture_filter_pkg::capture_sources_t sources_i,
    // Filter and channel state
    output logic filter_out_o,
    output logic channel_enable_o,
    output logic [1:0] timeout_control_field_o,
    output logic [capture_filter_pkg::VAL_W-1:0] main_count_o,
    output logic [capture_filter_pkg::TALLY_W-1:0] edge_tally_o
);
    import capture_filter_pkg::*;

    function automatic logic [VAL_W-1:0] pick_source(input logic ext, input logic [1:0] sel,
                                                    input capture_sources_t s,
                                                    input logic [TALLY_W-1:0] tally);
        logic [VAL_W-1:0] v;
        v = s.ts0;
        if (ext) begin
            if (sel == 2'b00) begin
                v = {{(VAL_W-TALLY_W){1'b0}}, tally};
            end
        end else begin
            case (sel)
                2'b00: v = s.ts0;
                2'b01: v = s.ts1;
                2'b10: v = s.ts2;
                2'b11: v = s.shadow_count;
                default: v = s.ts0;
            endcase
        end
        return v;
    endfunction

    logic [VAL_W-1:0] rise_filter_time_reg, rise_filter_time_next;
    logic [VAL_W-1:0] fall_filter_time_reg, fall_filter_time_next;
    logic [DATA_W-1:0] ctrl_reg, ctrl_next;
    logic [DATA_W-1:0] timeout_value_reg, timeout_value_next;
    logic [DATA_W-1:0] timeout_config_reg, timeout_config_next;
    logic [VAL_W-1:0] capture_a_value_reg, capture_a_value_next;
    logic [VAL_W-1:0] capture_b_value_reg, capture_b_value_next;
    logic [TALLY_W-1:0] edge_tally_reg, edge_tally_next;
    logic [VAL_W-1:0] main_count_reg, main_count_next;
    logic [VAL_W-1:0] filter_counter_reg, filter_counter_next;
    logic filter_out_reg, filter_out_next;
    logic enable_d_reg;
    filt_state_t filt_state_reg, filt_state_next;
    logic [DATA_W-1:0] rdata_reg, rdata_next;

    logic channel_enable;
    logic rise_filter_mode;
    logic fall_filter_mode;
    logic [1:0] filter_counter_clock_select;
    logic capture_a_ext_select;
    logic [1:0] capture_a_source_select;
    logic capture_b_ext_select;
    logic [1:0] capture_b_source_select;
    logic [2:0] channel_mode;
    logic enable_rise;
    logic filter_tick;
    logic [VAL_W-1:0] active_param;
    logic active_deglitch;
    logic edge_accept;

    assign channel_enable = ctrl_reg[CTRL_ENABLE_BIT];
    assign rise_filter_mode = ctrl_reg[CTRL_RISE_MODE_BIT];
    assign fall_filter_mode = ctrl_reg[CTRL_FALL_MODE_BIT];
    assign filter_counter_clock_select = ctrl_reg[CTRL_CLK_SEL_LSB +: 2];
    assign capture_a_source_select = ctrl_reg[CTRL_A_SRC_LSB +: 2];
    assign capture_a_ext_select = ctrl_reg[CTRL_A_EXT_BIT];
    assign capture_b_source_select = ctrl_reg[CTRL_B_SRC_LSB +: 2];
    assign capture_b_ext_select = ctrl_reg[CTRL_B_EXT_BIT];
    assign channel_mode = ctrl_reg[CTRL_MODE_LSB +: 3];
    assign enable_rise = channel_enable && !enable_d_reg;
    assign filter_tick = prescaled_clock_i[filter_counter_clock_select];

    // Pending edge direction picks which parameter and mode apply
    always_comb begin
        if (!filter_out_reg) begin
            active_param = rise_filter_time_reg;
            active_deglitch = rise_filter_mode;
        end else begin
            active_param = fall_filter_time_reg;
            active_deglitch = fall_filter_mode;
        end
    end

    // Edge filter
    always_comb begin
        filt_state_next = filt_state_reg;
        filter_counter_next = filter_counter_reg;
        filter_out_next = filter_out_reg;
        edge_accept = 1'b0;
        if (!channel_enable) begin
            filt_state_next = FILT_IDLE;
            filter_counter_next = VAL_ZERO;
            filter_out_next = filter_in_i;
        end else begin
            case (filt_state_reg)
                FILT_IDLE: begin
                    if (filter_in_i != filter_out_reg) begin
                        filter_counter_next = VAL_ZERO;
                        if (!active_deglitch) begin
                            // Immediate mode: pass edge, then hold for acceptance time
                            filter_out_next = filter_in_i;
                            edge_accept = 1'b1;
                        end
                        filt_state_next = FILT_TIMING;
                    end
                end
                FILT_TIMING: begin
                    if (filter_counter_reg >= active_param) begin
                        filt_state_next = FILT_IDLE;
                        filter_counter_next = VAL_ZERO;
                        if (filter_in_i != filter_out_reg) begin
                            filter_out_next = filter_in_i;
                            edge_accept = 1'b1;
                        end
                    end else if (active_deglitch && filter_in_i == filter_out_reg) begin
                        filt_state_next = FILT_IDLE;
                        filter_counter_next = VAL_ZERO;
                    end else if (filter_tick) begin
                        filter_counter_next = filter_counter_reg + CNT_ONE;
                    end
                end
                default: filt_state_next = FILT_IDLE;
            endcase
        end
    end

    // Edge tally, main count and captures
    always_comb begin
        edge_tally_next = edge_tally_reg;
        main_count_next = main_count_reg;
        capture_a_value_next = capture_a_value_reg;
        capture_b_value_next = capture_b_value_reg;
        if (enable_rise) begin
            edge_tally_next = {{(TALLY_W-1){1'b0}}, filter_out_next};
            main_count_next = VAL_ZERO;
            capture_a_value_next = VAL_ZERO;
            capture_b_value_next = VAL_ZERO;
        end else if (channel_enable) begin
            if (edge_accept) begin
                edge_tally_next = edge_tally_reg + 8'h01;
                main_count_next = main_count_reg + CNT_ONE;
            end
            if (capture_strobe_i) begin
                capture_a_value_next = pick_source(capture_a_ext_select,
                    capture_a_source_select, sources_i, edge_tally_reg);
                if (channel_mode == MODE_BIT_COMPRESSION) begin
                    capture_b_value_next = {{(VAL_W-1){1'b0}}, filter_out_reg};
                end else begin
                    capture_b_value_next = pick_source(capture_b_ext_select,
                        capture_b_source_select, sources_i, edge_tally_reg);
                end
            end
        end
        if (reg_req_i.wr && reg_req_i.addr == CAPTURE_VALUE_B_IDX
            && channel_mode == MODE_GATED_PERIODIC && !enable_rise) begin
            capture_b_value_next = reg_req_i.wdata[VAL_W-1:0];
        end
    end

    // Register writes and read mux; no legacy timeout duration register exists
    always_comb begin
        rise_filter_time_next = rise_filter_time_reg;
        fall_filter_time_next = fall_filter_time_reg;
        ctrl_next = ctrl_reg;
        timeout_value_next = timeout_value_reg;
        timeout_config_next = timeout_config_reg;
        rdata_next = REG_RESET;
        if (reg_req_i.wr) begin
            case (reg_req_i.addr)
                RISE_FILTER_PARAM_IDX: rise_filter_time_next = reg_req_i.wdata[VAL_W-1:0];
                FALL_FILTER_PARAM_IDX: fall_filter_time_next = reg_req_i.wdata[VAL_W-1:0];
                CHANNEL_CTRL_IDX: ctrl_next = reg_req_i.wdata & CTRL_WRITE_MASK;
                TIMEOUT_VALUE_IDX: timeout_value_next = reg_req_i.wdata;
                TIMEOUT_CONFIG_IDX: timeout_config_next = reg_req_i.wdata;
                default: ;
            endcase
        end
        if (reg_req_i.rd) begin
            case (reg_req_i.addr)
                RISE_FILTER_PARAM_IDX: rdata_next = {TALLY_ZERO, rise_filter_time_reg};
                FALL_FILTER_PARAM_IDX: rdata_next = {TALLY_ZERO, fall_filter_time_reg};
                CAPTURE_VALUE_A_IDX: rdata_next = {edge_tally_reg, capture_a_value_reg};
                CAPTURE_VALUE_B_IDX: rdata_next = {edge_tally_reg, capture_b_value_reg};
                CHANNEL_CTRL_IDX: rdata_next = ctrl_reg;
                TIMEOUT_VALUE_IDX: rdata_next = timeout_value_reg;
                TIMEOUT_CONFIG_IDX: rdata_next = timeout_config_reg;
                FILTER_STATUS_IDX: rdata_next = {7'h00, filter_out_reg, filter_counter_reg};
                default: rdata_next = REG_RESET;
            endcase
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            rise_filter_time_reg <= VAL_ZERO;
            fall_filter_time_reg <= VAL_ZERO;
            ctrl_reg <= REG_RESET;
            timeout_value_reg <= REG_RESET;
            timeout_config_reg <= REG_RESET;
            capture_a_value_reg <= VAL_ZERO;
            capture_b_value_reg <= VAL_ZERO;
            edge_tally_reg <= TALLY_ZERO;
            main_count_reg <= VAL_ZERO;
            filter_counter_reg <= VAL_ZERO;
            filter_out_reg <= 1'b0;
            enable_d_reg <= 1'b0;
            filt_state_reg <= FILT_IDLE;
            rdata_reg <= REG_RESET;
        end else begin
            rise_filter_time_reg <= rise_filter_time_next;
            fall_filter_time_reg <= fall_filter_time_next;
            ctrl_reg <= ctrl_next;
            timeout_value_reg <= timeout_value_next;
            timeout_config_reg <= timeout_config_next;
            capture_a_value_reg <= capture_a_value_next;
            capture_b_value_reg <= capture_b_value_next;
            edge_tally_reg <= edge_tally_next;
            main_count_reg <= main_count_next;
            filter_counter_reg <= filter_counter_next;
            filter_out_reg <= filter_out_next;
            enable_d_reg <= channel_enable;
            filt_state_reg <= filt_state_next;
            rdata_reg <= rdata_next;
        end
    end

    assign reg_rdata_o = rdata_reg;
    assign filter_out_o = filter_out_reg;
    assign channel_enable_o = channel_enable;
    assign timeout_control_field_o = ctrl_reg[CTRL_TO_CTRL_LSB +: 2];
    assign main_count_o = main_count_reg;
    assign edge_tally_o = edge_tally_reg;

    // Checks
    sequence s_edge_taken;
        channel_enable && !enable_rise && edge_accept;
    endsequence
    sequence s_timing_pending;
        channel_enable && filt_state_reg == FILT_TIMING && filter_counter_reg < active_param
        && filter_in_i != filter_out_reg;
    endsequence
    sequence s_capture_taken;
        channel_enable && !enable_rise && capture_strobe_i && !reg_req_i.wr;
    endsequence

    AST_PARAM_TOP_ZERO: assert property (@(posedge core_clk_i) disable iff (reset_i)
        reg_req_i.rd && reg_req_i.addr == RISE_FILTER_PARAM_IDX |=> reg_rdata_o[31:24] == 8'h00)
        else $error("parameter top byte not zero");
    AST_TALLY_STEP: assert property (@(posedge core_clk_i) disable iff (reset_i)
        s_edge_taken |=> edge_tally_reg == $past(edge_tally_reg) + 8'h01)
        else $error("tally did not step on edge");
    AST_TALLY_LEVEL: assert property (@(posedge core_clk_i) disable iff (reset_i)
        channel_enable && enable_d_reg |-> edge_tally_reg[0] == filter_out_reg)
        else $error("tally lsb differs from level");
    AST_ENABLE_CLEAR: assert property (@(posedge core_clk_i) disable iff (reset_i)
        enable_rise |=> edge_tally_reg[7:1] == 7'h00 && capture_a_value_reg == VAL_ZERO)
        else $error("enable did not clear state");
    AST_B_WRITE_GUARD: assert property (@(posedge core_clk_i) disable iff (reset_i)
        reg_req_i.wr && reg_req_i.addr == CAPTURE_VALUE_B_IDX && !capture_strobe_i
        && !enable_rise && channel_mode != MODE_GATED_PERIODIC
        |=> $stable(capture_b_value_reg))
        else $error("capture b written outside gated mode");
    AST_COMPRESS_B: assert property (@(posedge core_clk_i) disable iff (reset_i)
        channel_enable && !enable_rise && capture_strobe_i && channel_mode == MODE_BIT_COMPRESSION
        && !reg_req_i.wr |=> capture_b_value_reg[23:1] == 23'h00_0000)
        else $error("compression upper bits not zero");
    AST_A_READ_ONLY: assert property (@(posedge core_clk_i) disable iff (reset_i)
        !capture_strobe_i && !enable_rise |=> $stable(capture_a_value_reg))
        else $error("capture a changed without hardware");
    AST_IMMEDIATE_PASS: assert property (@(posedge core_clk_i) disable iff (reset_i)
        channel_enable && filt_state_reg == FILT_IDLE && !rise_filter_mode
        && !filter_out_reg && filter_in_i |=> filter_out_reg)
        else $error("immediate rise not propagated");
    AST_DEGLITCH_HOLD: assert property (@(posedge core_clk_i) disable iff (reset_i)
        channel_enable && filt_state_reg == FILT_TIMING && filter_counter_reg < active_param
        |=> filter_out_reg == $past(filter_out_reg))
        else $error("edge passed before filter time");
    AST_ENABLE_LSB: assert property (@(posedge core_clk_i) disable iff (reset_i)
        enable_rise |=> edge_tally_reg[0] == filter_out_reg)
        else $error("tally lsb not taken from filter level");
    AST_ENABLE_B_CLEAR: assert property (@(posedge core_clk_i) disable iff (reset_i)
        enable_rise |=> capture_b_value_reg == VAL_ZERO && main_count_reg == VAL_ZERO)
        else $error("enable did not clear capture b and count");
    AST_FALL_PASS: assert property (@(posedge core_clk_i) disable iff (reset_i)
        channel_enable && filt_state_reg == FILT_IDLE && !fall_filter_mode
        && filter_out_reg && !filter_in_i |=> !filter_out_reg)
        else $error("immediate fall not propagated");
    AST_DEGLITCH_ABORT: assert property (@(posedge core_clk_i) disable iff (reset_i)
        channel_enable && filt_state_reg == FILT_TIMING && active_deglitch
        && filter_counter_reg < active_param && filter_in_i == filter_out_reg
        |=> filt_state_reg == FILT_IDLE && filter_out_reg == $past(filter_out_reg))
        else $error("deglitch did not abort on return");
    AST_COUNT_HOLD: assert property (@(posedge core_clk_i) disable iff (reset_i)
        s_timing_pending ##0 !filter_tick |=> $stable(filter_counter_reg))
        else $error("filter counter moved without tick");
    AST_COUNT_STEP: assert property (@(posedge core_clk_i) disable iff (reset_i)
        s_timing_pending ##0 filter_tick
        |=> filter_counter_reg == $past(filter_counter_reg) + CNT_ONE)
        else $error("filter counter did not step on tick");
    AST_TALLY_HOLD: assert property (@(posedge core_clk_i) disable iff (reset_i)
        channel_enable && !enable_rise && !edge_accept |=> $stable(edge_tally_reg))
        else $error("tally moved without edge");
    AST_B_GATED_WRITE: assert property (@(posedge core_clk_i) disable iff (reset_i)
        reg_req_i.wr && reg_req_i.addr == CAPTURE_VALUE_B_IDX && !enable_rise
        && channel_mode == MODE_GATED_PERIODIC
        |=> capture_b_value_reg == $past(reg_req_i.wdata[VAL_W-1:0]))
        else $error("gated write to capture b lost");
    AST_COMPRESS_LSB: assert property (@(posedge core_clk_i) disable iff (reset_i)
        s_capture_taken ##0 (channel_mode == MODE_BIT_COMPRESSION)
        |=> capture_b_value_reg[0] == $past(filter_out_reg))
        else $error("compression lsb not filter level");
    AST_A_SOURCE: assert property (@(posedge core_clk_i) disable iff (reset_i)
        s_capture_taken ##0 (!capture_a_ext_select && capture_a_source_select == 2'b00)
        |=> capture_a_value_reg == $past(sources_i.ts0))
        else $error("capture a source mismatch");
    AST_B_SOURCE: assert property (@(posedge core_clk_i) disable iff (reset_i)
        s_capture_taken ##0 (channel_mode != MODE_BIT_COMPRESSION && !capture_b_ext_select
        && capture_b_source_select == 2'b01)
        |=> capture_b_value_reg == $past(sources_i.ts1))
        else $error("capture b source mismatch");
endmodule

// [verilog/capture_filter_pkg.sv]
package capture_filter_pkg;

    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;
    localparam int VAL_W = 24;
    localparam int TALLY_W = 8;

    // Register indices, byte address is four times the index
    localparam logic [ADDR_W-1:0] RISE_FILTER_PARAM_IDX = 4'h0;
    localparam logic [ADDR_W-1:0] FALL_FILTER_PARAM_IDX = 4'h1;
    localparam logic [ADDR_W-1:0] CAPTURE_VALUE_A_IDX = 4'h2;
    localparam logic [ADDR_W-1:0] CAPTURE_VALUE_B_IDX = 4'h3;
    localparam logic [ADDR_W-1:0] CHANNEL_CTRL_IDX = 4'h4;
    localparam logic [ADDR_W-1:0] TIMEOUT_VALUE_IDX = 4'h5;
    localparam logic [ADDR_W-1:0] TIMEOUT_CONFIG_IDX = 4'h6;
    localparam logic [ADDR_W-1:0] FILTER_STATUS_IDX = 4'h7;

    // Control register fields
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int CTRL_RISE_MODE_BIT = 1;
    localparam int CTRL_FALL_MODE_BIT = 2;
    localparam int CTRL_CLK_SEL_LSB = 3;
    localparam int CTRL_A_SRC_LSB = 5;
    localparam int CTRL_A_EXT_BIT = 7;
    localparam int CTRL_B_SRC_LSB = 8;
    localparam int CTRL_B_EXT_BIT = 10;
    localparam int CTRL_MODE_LSB = 11;
    localparam int CTRL_TO_CTRL_LSB = 14;
    localparam logic [DATA_W-1:0] CTRL_WRITE_MASK = 32'h0000_FFFF;

    localparam logic [DATA_W-1:0] REG_RESET = 32'h0000_0000;
    localparam logic [VAL_W-1:0] VAL_ZERO = 24'h00_0000;
    localparam logic [TALLY_W-1:0] TALLY_ZERO = 8'h00;
    localparam logic [VAL_W-1:0] CNT_ONE = 24'h00_0001;

    // Channel modes
    localparam logic [2:0] MODE_BIT_COMPRESSION = 3'h4;
    localparam logic [2:0] MODE_GATED_PERIODIC = 3'h5;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;

    typedef struct packed {
        logic [VAL_W-1:0] ts0;
        logic [VAL_W-1:0] ts1;
        logic [VAL_W-1:0] ts2;
        logic [VAL_W-1:0] shadow_count;
        logic [VAL_W-1:0] main_count;
    } capture_sources_t;

    typedef enum logic {
        FILT_IDLE,
        FILT_TIMING
    } filt_state_t;

endpackage

// [dv/input_source_model.sv]
`timescale 1ns/1ps
module input_source_model (
    // Clock and reset
    input wire logic core_clk_i,
    input wire logic reset_i,
    // Level commanded by the bench
    input wire logic level_i,
    // Towards the channel
    output logic filter_in_o,
    output logic [3:0] prescaled_clock_o
);
    logic [2:0] div_reg;
    logic [2:0] div_next;
    logic [3:0] tick_next;

    // Tick periods of 1, 2, 4 and 8 cycles, one pulse each
    always_comb begin
        div_next = div_reg + 3'h1;
        tick_next = {div_reg == 3'h7, div_reg[1:0] == 2'h3, div_reg[0], 1'b1};
    end

    always_ff @(posedge core_clk_i) begin
        if (reset_i) begin
            div_reg <= 3'h0;
            prescaled_clock_o <= 4'h0;
            filter_in_o <= 1'b0;
        end else begin
            div_reg <= div_next;
            prescaled_clock_o <= tick_next;
            filter_in_o <= level_i;
        end
    end
endmodule

// [dv/tb_input_capture_filter_regs.sv]
`timescale 1ns/1ps
module tb_input_capture_filter_regs;
    import capture_filter_pkg::*;

    typedef struct {
        logic [ADDR_W-1:0] a;
        logic [DATA_W-1:0] w;
        logic [DATA_W-1:0] e;
    } row_t;

    logic clk = 1'b0;
    logic rst = 1'b1;
    reg_req_t req = '0;
    logic level = 1'b0;
    logic strobe = 1'b0;
    capture_sources_t src = {24'hA0_0001, 24'hA0_0002, 24'hA0_0003, 24'hA0_0004, 24'hA0_0005};
    logic [DATA_W-1:0] reg_rdata_o;
    logic filter_in;
    logic [3:0] ticks;
    logic filter_out_o;
    logic channel_enable_o;
    logic [1:0] timeout_control_field_o;
    logic [VAL_W-1:0] main_count_o;
    logic [TALLY_W-1:0] edge_tally_o;
    logic [VAL_W-1:0] srcv [4];
    logic [VAL_W-1:0] v;
    row_t rows [7];
    int err_total = 0;
    int checks_done = 0;
    int cycles = 0;
    int p;

    input_capture_filter_regs i_dut (
        .core_clk_i(clk), .reset_i(rst), .reg_req_i(req), .reg_rdata_o(reg_rdata_o),
        .filter_in_i(filter_in), .prescaled_clock_i(ticks), .capture_strobe_i(strobe),
        .sources_i(src), .filter_out_o(filter_out_o), .channel_enable_o(channel_enable_o),
        .timeout_control_field_o(timeout_control_field_o), .main_count_o(main_count_o),
        .edge_tally_o(edge_tally_o)
    );

    input_source_model i_source (
        .core_clk_i(clk), .reset_i(rst), .level_i(level),
        .filter_in_o(filter_in), .prescaled_clock_o(ticks)
    );

    initial begin
        forever #25 clk = ~clk;
    end

    task automatic print_verdict;
        if (err_total == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            print_verdict();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_total++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tally_is(input logic [7:0] e);
        chk({24'h00_0000, edge_tally_o}, {24'h00_0000, e});
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk);
        req.wr <= 1'b1;
        req.addr <= a;
        req.wdata <= d;
        @(posedge clk);
        req.wr <= 1'b0;
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
        @(posedge clk);
        req.rd <= 1'b1;
        req.addr <= a;
        @(posedge clk);
        req.rd <= 1'b0;
        #1 chk(reg_rdata_o, e);
    endtask

    task automatic hold(input logic lv, input int n);
        @(posedge clk);
        level <= lv;
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic pulse;
        @(posedge clk);
        strobe <= 1'b1;
        @(posedge clk);
        strobe <= 1'b0;
    endtask

    function automatic logic [31:0] ctrl(input logic [1:0] md, input logic [2:0] a,
                                         input logic [2:0] b, input logic [2:0] mode,
                                         input logic [1:0] sel);
        logic [31:0] c;
        c = 32'h0000_0001;
        c[CTRL_RISE_MODE_BIT] = md[0];
        c[CTRL_FALL_MODE_BIT] = md[1];
        c[CTRL_CLK_SEL_LSB +: 2] = sel;
        c[CTRL_A_SRC_LSB +: 2] = a[1:0];
        c[CTRL_A_EXT_BIT] = a[2];
        c[CTRL_B_SRC_LSB +: 2] = b[1:0];
        c[CTRL_B_EXT_BIT] = b[2];
        c[CTRL_MODE_LSB +: 3] = mode;
        c[CTRL_TO_CTRL_LSB +: 2] = 2'h2;
        return c;
    endfunction

    initial begin
        rows = '{'{4'h0, 32'hFFFF_FFFF, 32'h00FF_FFFF}, '{4'h1, 32'hAB12_3456, 32'h0012_3456},
                 '{4'h2, 32'hFFFF_FFFF, 32'h0000_0000}, '{4'h3, 32'hFFFF_FFFF, 32'h0000_0000},
                 '{4'h8, 32'h1234_5678, 32'h0000_0000}, '{4'hF, 32'hFFFF_FFFF, 32'h0000_0000},
                 '{4'h1, 32'h0000_0000, 32'h0000_0000}};
        srcv = '{src.ts0, src.ts1, src.ts2, src.shadow_count};
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            rd(i[3:0], REG_RESET);
        end
        for (int i = 0; i < 7; i++) begin
            wr(rows[i].a, rows[i].w);
            rd(rows[i].a, rows[i].e);
        end
        // Immediate propagation, wide rising window swallows the glitch
        wr(RISE_FILTER_PARAM_IDX, 32'h0000_000C);
        wr(FALL_FILTER_PARAM_IDX, 32'h0000_0003);
        wr(CHANNEL_CTRL_IDX, ctrl(2'b00, 3'h0, 3'h0, 3'h0, 2'h0));
        hold(1'b0, 2);
        chk({31'h0, channel_enable_o}, 32'h0000_0001);
        chk({30'h0, timeout_control_field_o}, 32'h0000_0002);
        tally_is(8'h00);
        hold(1'b1, 20);
        tally_is(8'h01);
        hold(1'b0, 2);
        hold(1'b1, 2);
        hold(1'b0, 30);
        tally_is(8'h02);
        chk({31'h0, filter_out_o}, 32'h0000_0000);
        hold(1'b1, 20);
        tally_is(8'h03);
        chk({8'h00, main_count_o}, 32'h0000_0003);
        // Deglitch mode under every filter clock select
        wr(RISE_FILTER_PARAM_IDX, 32'h0000_0004);
        wr(FALL_FILTER_PARAM_IDX, 32'h0000_0004);
        for (int s = 0; s < 4; s++) begin
            p = 1 << s;
            hold(1'b0, 10);
            wr(CHANNEL_CTRL_IDX, REG_RESET);
            wr(CHANNEL_CTRL_IDX, ctrl(2'b11, 3'h0, 3'h0, 3'h0, s[1:0]));
            hold(1'b1, 2 * p);
            hold(1'b0, 8 * p + 6);
            tally_is(8'h00);
            hold(1'b1, 8 * p + 6);
            tally_is(8'h01);
            hold(1'b0, 2 * p);
            hold(1'b1, 8 * p + 6);
            tally_is(8'h01);
            hold(1'b0, 8 * p + 6);
            tally_is(8'h02);
        end
        // Enable in deglitch mode as the input moves: tally lsb follows filter output
        wr(CHANNEL_CTRL_IDX, REG_RESET);
        fork
            wr(CHANNEL_CTRL_IDX, ctrl(2'b11, 3'h0, 3'h0, 3'h0, 2'h0));
            hold(1'b1, 12);
        join
        tally_is(8'h01);
        chk({31'h0, filter_out_o}, 32'h0000_0001);
        // Every capture source with the input held high
        hold(1'b1, 12);
        for (int k = 0; k < 8; k++) begin
            v = (k < 4) ? srcv[k] : ((k == 4) ? 24'h00_0001 : src.ts0);
            wr(CHANNEL_CTRL_IDX, REG_RESET);
            wr(CHANNEL_CTRL_IDX, ctrl(2'b00, k[2:0], k[2:0], 3'h0, 2'h0));
            rd(CAPTURE_VALUE_A_IDX, 32'h0100_0000);
            pulse();
            rd(CAPTURE_VALUE_A_IDX, {8'h01, v});
            rd(CAPTURE_VALUE_B_IDX, {8'h01, v});
        end
        wr(CHANNEL_CTRL_IDX, REG_RESET);
        wr(CHANNEL_CTRL_IDX, ctrl(2'b00, 3'h0, 3'h1, MODE_BIT_COMPRESSION, 2'h0));
        pulse();
        rd(CAPTURE_VALUE_B_IDX, 32'h0100_0001);
        wr(CHANNEL_CTRL_IDX, REG_RESET);
        wr(CHANNEL_CTRL_IDX, ctrl(2'b00, 3'h0, 3'h0, MODE_GATED_PERIODIC, 2'h0));
        wr(CAPTURE_VALUE_B_IDX, 32'h00AB_CDEF);
        rd(CAPTURE_VALUE_B_IDX, 32'h01AB_CDEF);
        wr(CAPTURE_VALUE_A_IDX, 32'h00AB_CDEF);
        rd(CAPTURE_VALUE_A_IDX, 32'h0100_0000);
        // Reset in mid-run returns registers to zero
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd(CAPTURE_VALUE_B_IDX, REG_RESET);
        rd(RISE_FILTER_PARAM_IDX, REG_RESET);
        chk({31'h0, channel_enable_o}, 32'h0000_0000);
        print_verdict();
    end
endmodule
